// [hdl/cfg_seq_pkg.sv]
/*
 * Constants, register map and carrier types for the configuration
 * sequencer. Assumes a 100 MHz system clock and a 32-bit Avalon-MM slave.
 */
package cfg_seq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CRESET_MIN_NS = 320;
  // Least time, rounded up to whole cycles
  localparam int CRESET_CYC =
    (CRESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TUSER_MIN_US = 25;
  localparam int TUSER_CYC =
    (TUSER_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Chain extension, in config clock periods times bus width
  localparam int CHAIN_EXT_BITS = 1344;
  localparam int DIV_FOUR = 4;
  localparam int DIV_EIGHT = 8;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LEN = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_CMD = 4'hC;

  // Control fields
  localparam int CTRL_W = 7;
  localparam int CTRL_PASSIVE = 0;
  localparam int CTRL_JTAG = 1;
  localparam int CTRL_CLOCK_DIVIDE_BY_EIGHT = 2;
  localparam int CTRL_CHAIN = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_WIDTH_LO = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Image length in words (passive) or clock periods (active)
  localparam int LEN_W = 20;
  localparam logic [LEN_W-1:0] LEN_RESET = 20'h00100;

  // Status fields
  localparam int STAT_DONE = 0;
  localparam int STAT_USER = 1;
  localparam int STAT_CONFIG = 2;
  localparam int STAT_ENTERED = 3;
  localparam int STAT_RELEASE = 4;
  localparam int CMD_START = 0;

  localparam int WAIT_W = 16;
  localparam int LOW_W = 6;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CONFIG, ST_WAIT, ST_USER} state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avs_rsp_t;

endpackage

// [hdl/cfg_sync2.sv]
/*
 * Two flip-flop level synchroniser, one bit per lane.
 * Assumes inputs are levels or toggles slower than two clk periods.
 */
`timescale 1ns/1ps
module cfg_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("cfg_sync2: W must be at least 1");
  end

  // ****************************************************************
  // Two stages; only the second stage reads the first
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// [hdl/cfg_seq.sv]
/*
 * Configuration sequencer: reconfiguration reset filter, active and
 * passive image loading, done flag and user-mode wait with chain
 * extension. Assumes a 100 MHz clk, an Avalon-MM master, a host
 * driving cfg_clk in passive mode and a TAP reporting enter-user.
 */
// Overview of operation
// - A reset pin low under 320 ns is ignored; longer starts a load.
// - User mode follows only at least 25 us after config_done rises.
// - Core logic may be released when config_done rises, before the wait.
// - In JTAG loading the wait counts only once enter-user has been seen.
// - A parallel chain of width two or four forces a divide by four clock.
// - A chain master adds 1344 over bus width config clock periods of wait.
`timescale 1ns/1ps
module cfg_seq (
  input wire logic clk,
  input wire logic rst_b,
  input wire cfg_seq_pkg::avs_req_t avs_req,
  output cfg_seq_pkg::avs_rsp_t avs_rsp,
  input wire logic creset_b_pin,
  input wire logic enter_user_instr,
  input wire logic cfg_clk,
  input wire logic cfg_word_valid,
  output logic config_clock_pin_o,
  output logic config_clock_pin_oe,
  output logic config_done,
  output logic core_release,
  output logic user_mode,
  output logic sys_if_rst_b
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    cfg_seq_pkg::state_t st;
    logic [cfg_seq_pkg::CTRL_W-1:0] ctrl;
    logic [cfg_seq_pkg::LEN_W-1:0] len;
    logic [cfg_seq_pkg::LEN_W-1:0] word_cnt;
    logic [cfg_seq_pkg::LOW_W-1:0] low_cnt;
    logic [cfg_seq_pkg::WAIT_W-1:0] wait_cnt;
    logic [2:0] div_cnt;
    logic cr_prev;
    logic tgl_prev;
    logic entered;
    logic done;
    logic release_q;
    logic user;
    logic clk_out;
    logic clk_oe;
    logic waitreq;
    logic [31:0] rdata;
  } seq_t;

  localparam seq_t SEQ_RST = '{
    st: cfg_seq_pkg::ST_IDLE,
    ctrl: cfg_seq_pkg::CTRL_RESET,
    len: cfg_seq_pkg::LEN_RESET,
    word_cnt: '0,
    low_cnt: '0,
    wait_cnt: '0,
    div_cnt: '0,
    cr_prev: 1'b1,
    tgl_prev: 1'b0,
    entered: 1'b0,
    done: 1'b0,
    release_q: 1'b0,
    user: 1'b0,
    clk_out: 1'b0,
    clk_oe: 1'b0,
    waitreq: 1'b1,
    rdata: '0
  };

  seq_t s_q;
  seq_t s_d;
  logic word_tgl_q;
  logic [2:0] sync_q;
  logic cr_s;
  logic enter_s;
  logic tgl_s;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Effective active clock ratio
  function automatic logic [3:0] eff_div(
    input logic [cfg_seq_pkg::CTRL_W-1:0] c
  );
    logic [1:0] w;
    w = c[cfg_seq_pkg::CTRL_WIDTH_LO +: 2];
    if (c[cfg_seq_pkg::CTRL_CHAIN] && (w == 2'h1 || w == 2'h2))
      return 4'(cfg_seq_pkg::DIV_FOUR);
    return c[cfg_seq_pkg::CTRL_CLOCK_DIVIDE_BY_EIGHT] ? 4'(cfg_seq_pkg::DIV_EIGHT)
                                     : 4'(cfg_seq_pkg::DIV_FOUR);
  endfunction

  // Extra wait for a chain master, in clk cycles
  function automatic logic [cfg_seq_pkg::WAIT_W-1:0] ext_cyc(
    input logic [cfg_seq_pkg::CTRL_W-1:0] c
  );
    int bits;
    bits = cfg_seq_pkg::CHAIN_EXT_BITS >> c[cfg_seq_pkg::CTRL_WIDTH_LO +: 2];
    if (!c[cfg_seq_pkg::CTRL_MASTER])
      return '0;
    return cfg_seq_pkg::WAIT_W'(bits * int'(eff_div(c)));
  endfunction

  // Byte-enable merge
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // ****************************************************************
  // Link domain: one toggle per word the host clocks in
  // ****************************************************************
  always_ff @(posedge cfg_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_tgl_q <= 1'b0;
    end else if (cfg_word_valid) begin
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // Pins and link toggle into clk domain
  cfg_sync2 #(.W(3), .INIT(3'h4)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({creset_b_pin, enter_user_instr, word_tgl_q}),
    .q(sync_q)
  );
  assign cr_s = sync_q[2];
  assign enter_s = sync_q[1];
  assign tgl_s = sync_q[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic start;
    logic [31:0] cw;
    logic [3:0] half;
    start = 1'b0;
    cw = '0;
    half = eff_div(s_q.ctrl) >> 1;
    s_d = s_q;
    s_d.cr_prev = cr_s;
    s_d.tgl_prev = tgl_s;

    // Bus: waitrequest drops for exactly one cycle per request
    s_d.waitreq = !((avs_req.read || avs_req.write) && s_q.waitreq);
    if ((avs_req.read || avs_req.write) && s_q.waitreq) begin
      case (avs_req.address)
        cfg_seq_pkg::ADDR_CTRL: s_d.rdata = 32'(s_q.ctrl);
        cfg_seq_pkg::ADDR_LEN: s_d.rdata = 32'(s_q.len);
        cfg_seq_pkg::ADDR_STAT: begin
          s_d.rdata = '0;
          s_d.rdata[cfg_seq_pkg::STAT_DONE] = s_q.done;
          s_d.rdata[cfg_seq_pkg::STAT_USER] = s_q.user;
          s_d.rdata[cfg_seq_pkg::STAT_CONFIG] =
            (s_q.st == cfg_seq_pkg::ST_CONFIG);
          s_d.rdata[cfg_seq_pkg::STAT_ENTERED] = s_q.entered;
          s_d.rdata[cfg_seq_pkg::STAT_RELEASE] = s_q.release_q;
        end
        default: s_d.rdata = '0;
      endcase
    end
    if (avs_req.write && !s_q.waitreq) begin
      case (avs_req.address)
        cfg_seq_pkg::ADDR_CTRL: begin
          cw = merge(32'(s_q.ctrl), avs_req.writedata, avs_req.byteenable);
          s_d.ctrl = cw[cfg_seq_pkg::CTRL_W-1:0];
        end
        cfg_seq_pkg::ADDR_LEN: begin
          cw = merge(32'(s_q.len), avs_req.writedata, avs_req.byteenable);
          s_d.len = cw[cfg_seq_pkg::LEN_W-1:0];
        end
        cfg_seq_pkg::ADDR_CMD: begin
          start = avs_req.byteenable[0] &&
                  avs_req.writedata[cfg_seq_pkg::CMD_START];
        end
        default: ;
      endcase
    end

    // Reconfiguration reset width filter
    if (!cr_s) begin
      if (s_q.low_cnt != '1) s_d.low_cnt = s_q.low_cnt + 6'h01;
    end else begin
      s_d.low_cnt = '0;
    end
    if (cr_s && !s_q.cr_prev && s_q.low_cnt >= cfg_seq_pkg::CRESET_CYC)
      start = 1'b1;

    case (s_q.st)
      cfg_seq_pkg::ST_CONFIG: begin
        if (s_q.ctrl[cfg_seq_pkg::CTRL_PASSIVE] ||
            s_q.ctrl[cfg_seq_pkg::CTRL_JTAG]) begin
          if (tgl_s != s_q.tgl_prev) s_d.word_cnt = s_q.word_cnt + 20'h00001;
        end else begin
          // Active mode: drive config clock from clk
          s_d.clk_oe = 1'b1;
          s_d.div_cnt = s_q.div_cnt + 3'h1;
          if (s_q.div_cnt == 3'(half - 4'h1)) begin
            s_d.div_cnt = '0;
            s_d.clk_out = !s_q.clk_out;
            if (!s_q.clk_out) s_d.word_cnt = s_q.word_cnt + 20'h00001;
          end
        end
        if (s_q.word_cnt >= s_q.len) begin
          s_d.done = 1'b1;
          s_d.release_q = 1'b1;
          s_d.clk_oe = 1'b0;
          s_d.clk_out = 1'b0;
          s_d.st = cfg_seq_pkg::ST_WAIT;
        end
      end
      cfg_seq_pkg::ST_WAIT: begin
        if (enter_s) s_d.entered = 1'b1;
        if (!s_q.ctrl[cfg_seq_pkg::CTRL_JTAG] || s_q.entered)
          s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
        if (s_q.wait_cnt >=
            16'(cfg_seq_pkg::TUSER_CYC) + ext_cyc(s_q.ctrl)) begin
          s_d.user = 1'b1;
          s_d.st = cfg_seq_pkg::ST_USER;
        end
      end
      default: ;
    endcase

    // Long low pulse aborts; release or command restarts loading
    if (!cr_s && s_q.low_cnt >= cfg_seq_pkg::CRESET_CYC) begin
      s_d.st = cfg_seq_pkg::ST_IDLE;
      s_d.done = 1'b0;
      s_d.release_q = 1'b0;
      s_d.user = 1'b0;
      s_d.clk_oe = 1'b0;
      s_d.clk_out = 1'b0;
    end
    if (start) begin
      s_d.st = cfg_seq_pkg::ST_CONFIG;
      s_d.word_cnt = '0;
      s_d.wait_cnt = '0;
      s_d.div_cnt = '0;
      s_d.entered = 1'b0;
      s_d.done = 1'b0;
      s_d.release_q = 1'b0;
      s_d.user = 1'b0;
      s_d.clk_out = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) s_q <= SEQ_RST;
    else s_q <= s_d;
  end

  // Outputs straight from the state record
  assign avs_rsp.readdata = s_q.rdata;
  assign avs_rsp.waitrequest = s_q.waitreq;
  assign config_clock_pin_o = s_q.clk_out;
  assign config_clock_pin_oe = s_q.clk_oe;
  assign config_done = s_q.done;
  assign core_release = s_q.release_q;
  assign user_mode = s_q.user;
  assign sys_if_rst_b = s_q.user;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // All checks run on clk and rest while rst_b is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_short_pulse_ignored: assert property (
    (s_q.st == cfg_seq_pkg::ST_USER && cr_s && !s_q.cr_prev &&
     s_q.low_cnt < cfg_seq_pkg::CRESET_CYC && !avs_req.write)
    |=> s_q.st == cfg_seq_pkg::ST_USER)
    else $error("short reset pulse restarted loading");

  a_user_after_min: assert property (
    $rose(s_q.user) |-> $past(s_q.wait_cnt) >= cfg_seq_pkg::TUSER_CYC)
    else $error("user mode entered before the minimum wait");

  a_early_release: assert property (
    $rose(s_q.done) |-> s_q.release_q && !s_q.user)
    else $error("core release not raised with done");

  a_if_reset_held: assert property (
    $rose(sys_if_rst_b) |-> s_q.done &&
      $past(s_q.wait_cnt) >= cfg_seq_pkg::TUSER_CYC)
    else $error("interface reset released before the wait ended");

  a_jtag_gate: assert property (
    (s_q.st == cfg_seq_pkg::ST_WAIT && s_q.ctrl[cfg_seq_pkg::CTRL_JTAG] &&
     !s_q.entered) ##1 (s_q.st == cfg_seq_pkg::ST_WAIT)
    |-> $stable(s_q.wait_cnt))
    else $error("jtag wait counted before enter-user");

  a_chain_clock_divide_by_four: assert property (
    s_q.clk_oe && s_q.ctrl[cfg_seq_pkg::CTRL_CHAIN] &&
    s_q.ctrl[cfg_seq_pkg::CTRL_WIDTH_LO +: 2] inside {2'h1, 2'h2}
    |-> s_q.div_cnt < 3'h2)
    else $error("chain width two or four not divided by four");

  a_master_extend: assert property (
    $rose(s_q.user) |-> $past(s_q.wait_cnt) >=
      16'(cfg_seq_pkg::TUSER_CYC) + ext_cyc(s_q.ctrl))
    else $error("chain master wait not extended");

  a_done_low_load: assert property (
    s_q.st == cfg_seq_pkg::ST_CONFIG && s_q.word_cnt < s_q.len
    |=> !s_q.done [*1] or s_q.st != cfg_seq_pkg::ST_CONFIG)
    else $error("done high while loading");

  a_bus_one_wait: assert property (
    !avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule

// [dv/cfg_host_model.sv]
/*
 * Behavioural passive configuration host: sends a frame of words on its
 * own link clock. Assumes the bench raises go, holds it until frame_done
 * and drops it again before the next frame.
 */
`timescale 1ns/1ps
module cfg_host_model #(
  parameter int HALF_NS = 24,
  parameter int LEAD_NS = 200
) (
  input wire logic go,
  input wire logic [7:0] nwords,
  output logic cfg_clk,
  output logic cfg_word_valid,
  output logic frame_done
);
  // ****************************************************************
  // Frame engine
  // ****************************************************************
  // Link clock runs only inside a frame and stands low between frames
  initial begin
    cfg_clk = 1'b0;
    cfg_word_valid = 1'b0;
    frame_done = 1'b0;
    #7;
    forever begin
      wait (go === 1'b1);
      frame_done = 1'b0;
      #(LEAD_NS);
      repeat (nwords) begin
        cfg_word_valid = 1'b1;
        #(HALF_NS) cfg_clk = 1'b1;
        #(HALF_NS) cfg_clk = 1'b0;
      end
      cfg_word_valid = 1'b0;
      frame_done = 1'b1;
      wait (go === 1'b0);
    end
  end
endmodule

// [dv/fpga_config_sequencing_test.sv]
/*
 * Self-checking bench for the configuration sequencer: registers,
 * passive, reconfiguration pin, JTAG and active chain loading.
 * Assumes cfg_seq with its Avalon-MM slave answering in one cycle.
 */
`timescale 1ns/1ps
module fpga_config_sequencing_test;
  logic clk, rst_b, creset_b_pin, enter_user_instr;
  logic cfg_clk, cfg_word_valid, clk_pin_o, clk_pin_oe;
  logic config_done, core_release, user_mode, sys_if_rst_b;
  logic go, frame_done;
  logic [7:0] nwords;
  cfg_seq_pkg::avs_req_t avs_req;
  cfg_seq_pkg::avs_rsp_t avs_rsp;
  int errors, checks;
  localparam int TU = cfg_seq_pkg::TUSER_CYC;

  cfg_seq i_dut (.clk(clk), .rst_b(rst_b), .avs_req(avs_req),
    .avs_rsp(avs_rsp), .creset_b_pin(creset_b_pin),
    .enter_user_instr(enter_user_instr), .cfg_clk(cfg_clk),
    .cfg_word_valid(cfg_word_valid), .config_clock_pin_o(clk_pin_o),
    .config_clock_pin_oe(clk_pin_oe), .config_done(config_done),
    .core_release(core_release), .user_mode(user_mode),
    .sys_if_rst_b(sys_if_rst_b));

  cfg_host_model i_host (.go(go), .nwords(nwords), .cfg_clk(cfg_clk),
    .cfg_word_valid(cfg_word_valid), .frame_done(frame_done));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // Common tasks
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    errors++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
    checks++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi,
                         input string msg);
    checks++;
    if (got < lo || got > hi) fail(msg);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return config_done;
      1: return user_mode;
      2: return clk_pin_oe;
      3: return ~clk_pin_o;
      4: return clk_pin_o;
      default: return frame_done;
    endcase
  endfunction

  // Counts falling edges until the chosen signal is high
  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    while (pick(sel) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (pick(sel) !== 1'b1) begin
      fail("wait timed out");
      end_sim;
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
    if (avs_rsp.waitrequest !== 1'b0) begin
      fail("bus timed out");
      end_sim;
    end
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input string msg);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_val(q, exp, msg);
  endtask

  task automatic send_words(input logic [7:0] cnt);
    int n;
    @(posedge clk);
    nwords <= cnt;
    go <= 1'b1;
    repeat (2) @(negedge clk);
    wait_for(5, 2000, n);
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic load(input logic [31:0] ctrl, input logic [31:0] len);
    wr(cfg_seq_pkg::ADDR_CTRL, ctrl);
    wr(cfg_seq_pkg::ADDR_LEN, len);
    wr(cfg_seq_pkg::ADDR_CMD, 32'h1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd_chk(cfg_seq_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    rd_chk(cfg_seq_pkg::ADDR_LEN, 32'h100, "len reset");
    rd_chk(cfg_seq_pkg::ADDR_STAT, 32'h0, "stat reset");
    wr(cfg_seq_pkg::ADDR_LEN, 32'hFFF12345);
    rd_chk(cfg_seq_pkg::ADDR_LEN, 32'h12345, "len width");
    @(posedge clk);
    avs_req.byteenable <= 4'h2;
    wr(cfg_seq_pkg::ADDR_LEN, 32'h0000AB00);
    @(posedge clk);
    avs_req.byteenable <= 4'hF;
    rd_chk(cfg_seq_pkg::ADDR_LEN, 32'h1AB45, "len lane merge");
    wr(cfg_seq_pkg::ADDR_STAT, 32'h1F);
    rd_chk(cfg_seq_pkg::ADDR_STAT, 32'h0, "stat read only");
    wr(4'h2, 32'hFFFFFFFF);
    rd_chk(4'h2, 32'h0, "unmapped read");
    rd_chk(cfg_seq_pkg::ADDR_CMD, 32'h0, "cmd reads zero");
    $display("test regs finished");
  endtask

  task automatic t_passive;
    int n;
    load(32'h1, 32'h4);
    rd_chk(cfg_seq_pkg::ADDR_STAT, 32'h4, "configuring");
    send_words(8'h3);
    repeat (10) @(negedge clk);
    chk_val({31'h0, config_done}, 32'h0, "done early");
    send_words(8'h1);
    wait_for(0, 100, n);
    chk_val({29'h0, core_release, user_mode, sys_if_rst_b}, 32'h4,
            "early release");
    wait_for(1, 20000, n);
    chk_rng(n, TU, TU + 8, "user wait");
    chk_val({31'h0, sys_if_rst_b}, 32'h1, "if reset");
    rd_chk(cfg_seq_pkg::ADDR_STAT, 32'h13, "stat user");
    $display("test passive finished");
  endtask

  task automatic pulse(input int cyc);
    @(posedge clk);
    creset_b_pin <= 1'b0;
    repeat (cyc) @(posedge clk);
    creset_b_pin <= 1'b1;
  endtask

  task automatic t_creset;
    int n;
    pulse(28);
    repeat (10) @(negedge clk);
    chk_val({31'h0, config_done}, 32'h1, "short pulse");
    pulse(40);
    repeat (8) @(negedge clk);
    rd_chk(cfg_seq_pkg::ADDR_STAT, 32'h4, "reload");
    send_words(8'h4);
    wait_for(0, 100, n);
    $display("test creset finished");
  endtask

  task automatic t_jtag;
    int n;
    load(32'h2, 32'h2);
    send_words(8'h2);
    wait_for(0, 100, n);
    repeat (3000) @(negedge clk);
    chk_val({31'h0, user_mode}, 32'h0, "no enter user");
    @(posedge clk);
    enter_user_instr <= 1'b1;
    wait_for(1, 20000, n);
    chk_rng(n, TU, TU + 8, "jtag wait");
    @(posedge clk);
    enter_user_instr <= 1'b0;
    $display("test jtag finished");
  endtask

  // Active load, single device, divide by eight left in force
  task automatic t_clock_divide_by_eight;
    int n, a, b;
    load(32'h4, 32'h3);
    wait_for(2, 50, n);
    wait_for(4, 20, n);
    wait_for(3, 20, a);
    wait_for(4, 20, b);
    chk_rng(a + b, 8, 8, "clock_divide_by_eight clock");
    wait_for(0, 200, n);
    chk_val({31'h0, clk_pin_oe}, 32'h0, "clock released");
    wait_for(1, 20000, n);
    chk_rng(n, TU, TU + 8, "single wait");
    $display("test clock_divide_by_eight finished");
  endtask

  task automatic t_chain;
    int n, lo, hi, ext;
    ext = (cfg_seq_pkg::CHAIN_EXT_BITS >> 1) * cfg_seq_pkg::DIV_FOUR;
    load(32'h3C, 32'h8);
    wait_for(2, 50, n);
    wait_for(3, 20, n);
    wait_for(4, 20, n);
    wait_for(3, 20, lo);
    wait_for(4, 20, hi);
    chk_rng(lo + hi, 4, 4, "clock divide");
    wait_for(0, 200, n);
    wait_for(1, 20000, n);
    chk_rng(n, TU + ext, TU + ext + 8, "chain wait");
    $display("test chain finished");
  endtask

  // Main sequence
  initial begin
    errors = 0;
    checks = 0;
    rst_b = 1'b0;
    creset_b_pin = 1'b1;
    enter_user_instr = 1'b0;
    go = 1'b0;
    nwords = 8'h0;
    avs_req = '0;
    avs_req.byteenable = 4'hF;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_passive;
    t_creset;
    t_jtag;
    t_clock_divide_by_eight;
    t_chain;
    end_sim;
  end
endmodule
